/* File: rtl/nvh_defs.vh */
`ifndef NVH_DEFS_VH
`define NVH_DEFS_VH
// Clock period in picoseconds (200 MHz)
`define NVH_CLK_PS 5000
// Device timings in ns, selected by grade (0 = fast, 1 = slow) where a FAST/SLOW pair is given
`define NVH_T_AA_FAST 35
`define NVH_T_AA_SLOW 45
`define NVH_T_OE_FAST 15
`define NVH_T_OE_SLOW 20
`define NVH_T_HZ_FAST 13
`define NVH_T_HZ_SLOW 15
`define NVH_T_DW_FAST 12
`define NVH_T_DW_SLOW 15
`define NVH_T_CW_FAST 25
`define NVH_T_CW_SLOW 30
`define NVH_T_OW 5
`define NVH_T_OH 5
// Power sequencing times
`define NVH_T_DELAY_NS 1000
`define NVH_T_RESTORE_US 550
`define NVH_T_STORE_MS 10
// Widths
`define NVH_AW 17
`define NVH_DW 8
`define NVH_CW 24
`endif

/* File: rtl/nvh_seq_timer.v */
`default_nettype none
// Down counter: loads a cycle count and flags when it has run out
module nvh_seq_timer (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Control
    input wire load,
    input wire [23:0] count,
    // Status
    output reg done_q
);
    reg [23:0] cnt_q;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 24'h00_0000;
            done_q <= 1'b1;
        end else if (load) begin
            cnt_q <= count;
            done_q <= (count == 24'h00_0000);
        end else if (cnt_q != 24'h00_0000) begin
            cnt_q <= cnt_q - 24'h00_0001;
            done_q <= (cnt_q == 24'h00_0001);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/nvh_host.v */
// Operation
// R1: Read happens with select and output enable low, write enable high.
// R2: Seventeen address bits pick one byte of the array.
// R3: Address-started read data valid after 35 or 45 ns.
// R4: Strobe-started read valid at later of select and output-enable access.
// R5: Outputs follow address while selected; valid until change or deselect.
// R6: Old data held at least 5 ns after address change.
// R7: Device floats outputs within 13 or 15 ns of deselect.
// R8: Write happens with select and write enable low.
// R9: Host holds address stable across the whole write.
// R10: Host sets data 12 or 15 ns before write end, holds after.
// R11: Host holds select and address 25 or 30 ns before write end.
// R12: Output enable low in a write: device floats within 13/15 ns.
// R13: Write enable low at select fall keeps outputs floating.
// R14: Device drives no output until 5 ns after write end.
// R15: Power fail copies array to nonvolatile store within 10 ms.
// R16: Store skipped unless a write occurred since last store or recall.
// R17: Access in progress gets 1 us to finish before store.
// R18: Power-up latches recall; recall completes within 550 us.
// R19: Host never leaves a write active when recall ends.
// R20: Low supply inhibits external writes and store requests.
// R21: Power-good input models supply; accesses ignored during store or recall.
`default_nettype none
`include "nvh_defs.vh"
module nvh_host #(
    parameter GRADE = 0,
    parameter RESTORE_CYC = (`NVH_T_RESTORE_US * 1000000 + `NVH_CLK_PS - 1) / `NVH_CLK_PS,
    // Cycles per ms taken first so the product stays inside 32 bits
    parameter STORE_CYC = `NVH_T_STORE_MS * (1000000000 / `NVH_CLK_PS)
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // User request side
    input wire req_valid,
    input wire req_write,
    input wire [16:0] req_addr,
    input wire [7:0] req_wdata,
    output reg req_ready_q,
    output reg rsp_valid_q,
    output reg [7:0] rsp_rdata_q,
    // Supply status
    input wire power_good,
    output reg mem_busy_q,
    // Device pins
    output reg [16:0] addr_in_q,
    output reg chip_sel_n_q,
    output reg out_en_n_q,
    output reg wr_en_n_q,
    input wire [7:0] data_bus_i,
    output reg [7:0] data_bus_o_q,
    output reg data_bus_oe_q
);
    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam integer T_AA = GRADE ? `NVH_T_AA_SLOW : `NVH_T_AA_FAST;
    localparam integer T_OE = GRADE ? `NVH_T_OE_SLOW : `NVH_T_OE_FAST;
    localparam integer T_HZ = GRADE ? `NVH_T_HZ_SLOW : `NVH_T_HZ_FAST;
    localparam integer T_DW = GRADE ? `NVH_T_DW_SLOW : `NVH_T_DW_FAST;
    localparam integer T_CW = GRADE ? `NVH_T_CW_SLOW : `NVH_T_CW_FAST;
    // Read waits the slowest access path, since select and OE fall together
    localparam integer T_RD = (T_AA > T_OE) ? T_AA : T_OE;
    localparam integer RD_CYC = (T_RD * 1000 + `NVH_CLK_PS - 1) / `NVH_CLK_PS + 2;
    localparam integer CW_TMP = (T_CW > T_DW) ? T_CW : T_DW;
    localparam integer WR_CYC = (CW_TMP * 1000 + `NVH_CLK_PS - 1) / `NVH_CLK_PS;
    localparam integer HZ_TMP = (T_HZ > `NVH_T_OW) ? T_HZ : `NVH_T_OW;
    localparam integer HZ_CYC = (HZ_TMP * 1000 + `NVH_CLK_PS - 1) / `NVH_CLK_PS;
    localparam integer DLY_CYC = (`NVH_T_DELAY_NS * 1000 + `NVH_CLK_PS - 1) / `NVH_CLK_PS;

    // ************************************************************
    // States
    // ************************************************************
    localparam [6:0] S_OFF = 7'h01;
    localparam [6:0] S_RECALL = 7'h02;
    localparam [6:0] S_IDLE = 7'h04;
    localparam [6:0] S_READ = 7'h08;
    localparam [6:0] S_WRITE = 7'h10;
    localparam [6:0] S_GAP = 7'h20;
    localparam [6:0] S_STORE = 7'h40;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    reg [1:0] pg_sync_q;
    reg [7:0] dq_meta_q;
    reg [7:0] dq_sync_q;
    wire pg = pg_sync_q[1];

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pg_sync_q <= 2'h0;
            dq_meta_q <= 8'h00;
            dq_sync_q <= 8'h00;
        end else begin
            pg_sync_q <= {pg_sync_q[0], power_good};
            dq_meta_q <= data_bus_i;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    reg [6:0] state_q;
    reg [6:0] state_d;
    reg tmr_load;
    reg [23:0] tmr_count;
    wire tmr_done;
    reg dirty_q;

    nvh_seq_timer u_tmr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .count(tmr_count),
        .done_q(tmr_done)
    );

    always @* begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_count = 24'h00_0000;
        case (state_q)
            S_OFF: begin
                if (pg) begin
                    state_d = S_RECALL; // R18
                    tmr_load = 1'b1;
                    tmr_count = RESTORE_CYC[23:0];
                end
            end
            S_RECALL: begin
                if (!pg) begin
                    state_d = S_OFF;
                end else if (tmr_done) begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE: begin
                if (!pg) begin
                    state_d = S_STORE; // R15
                    tmr_load = 1'b1;
                    tmr_count = dirty_q ? STORE_CYC[23:0] : 24'h00_0000; // R16
                end else if (req_valid) begin
                    state_d = req_write ? S_WRITE : S_READ; // R1 R8
                    tmr_load = 1'b1;
                    tmr_count = req_write ? WR_CYC[23:0] : RD_CYC[23:0];
                end
            end
            S_READ, S_WRITE: begin
                // Cycle completes within the 1 us grace even if power fails
                if (tmr_done) begin // R17
                    state_d = S_GAP;
                    tmr_load = 1'b1;
                    tmr_count = HZ_CYC[23:0];
                end
            end
            S_GAP: begin
                if (tmr_done) begin
                    state_d = pg ? S_IDLE : S_STORE;
                    tmr_load = 1'b1;
                    tmr_count = pg ? 24'h00_0000 : (dirty_q ? STORE_CYC[23:0] : 24'h00_0000);
                end
            end
            S_STORE: begin
                // Store runs to completion; a recall follows once power returns
                if (tmr_done) begin
                    state_d = S_OFF;
                end
            end
            default: begin
                state_d = S_OFF;
            end
        endcase
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_OFF;
            dirty_q <= 1'b0;
            addr_in_q <= 17'h0_0000;
            chip_sel_n_q <= 1'b1;
            out_en_n_q <= 1'b1;
            wr_en_n_q <= 1'b1;
            data_bus_o_q <= 8'h00;
            data_bus_oe_q <= 1'b0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            mem_busy_q <= 1'b1;
        end else begin
            state_q <= state_d;
            rsp_valid_q <= 1'b0;
            req_ready_q <= (state_d == S_IDLE) && (state_q != S_IDLE);
            mem_busy_q <= (state_d == S_OFF) || (state_d == S_RECALL) || (state_d == S_STORE); // R21
            if (state_q == S_RECALL && tmr_done) begin
                dirty_q <= 1'b0;
            end
            if (state_q == S_STORE && tmr_done) begin
                dirty_q <= 1'b0;
            end
            case (state_d)
                S_READ: begin
                    if (state_q == S_IDLE) begin
                        addr_in_q <= req_addr; // R2
                        chip_sel_n_q <= 1'b0;
                        out_en_n_q <= 1'b0;
                        wr_en_n_q <= 1'b1; // R1
                    end
                end
                S_WRITE: begin
                    if (state_q == S_IDLE) begin
                        addr_in_q <= req_addr; // R9
                        data_bus_o_q <= req_wdata;
                        data_bus_oe_q <= 1'b1; // R10
                        chip_sel_n_q <= 1'b0; // R11
                        out_en_n_q <= 1'b1; // R12
                        wr_en_n_q <= 1'b0; // R8 R13
                        dirty_q <= 1'b1;
                    end
                end
                S_GAP: begin
                    if (state_q == S_READ) begin
                        rsp_rdata_q <= dq_sync_q; // R3 R4 R5 R6
                        rsp_valid_q <= 1'b1;
                    end
                    // Address held; strobes rise first, data held one cycle (5 ns) after
                    chip_sel_n_q <= 1'b1; // R7 R14
                    out_en_n_q <= 1'b1;
                    wr_en_n_q <= 1'b1; // R19
                    if (state_q == S_GAP) begin
                        data_bus_oe_q <= 1'b0;
                    end
                end
                default: begin
                    chip_sel_n_q <= 1'b1;
                    out_en_n_q <= 1'b1;
                    wr_en_n_q <= 1'b1; // R19 R20
                    data_bus_oe_q <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: test/nvh_host_checker.sv */
`default_nettype none
module nvh_host_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Host outputs
    input wire logic rsp_valid_q,
    input wire logic mem_busy_q,
    input wire logic [16:0] addr_in_q,
    input wire logic chip_sel_n_q,
    input wire logic out_en_n_q,
    input wire logic wr_en_n_q,
    input wire logic [7:0] data_bus_o_q,
    input wire logic data_bus_oe_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Pin protocol
    // ****************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    wire wr_on = !chip_sel_n_q && !wr_en_n_q;
    wire rd_on = !out_en_n_q && !chip_sel_n_q;
    a_addr_hold_write: assert property (wr_on && $past(wr_on) |-> $stable(addr_in_q))
        else $error("address moved in write");
    a_data_in_write: assert property (wr_on |-> data_bus_oe_q)
        else $error("write data not driven");
    a_data_hold_end: assert property ($rose(wr_en_n_q) |-> data_bus_oe_q && $stable(data_bus_o_q))
        else $error("write data not held");
    a_select_setup: assert property ($rose(wr_en_n_q) |-> $past(wr_on, 5) && $past(wr_on))
        else $error("write pulse too short");
    a_no_bus_fight: assert property (!out_en_n_q |-> !data_bus_oe_q)
        else $error("host drives during read");
    a_read_we_high: assert property (!out_en_n_q |-> wr_en_n_q)
        else $error("read with write enable");
    a_read_access: assert property (rsp_valid_q |-> $past(rd_on, 8))
        else $error("read data taken early");
    a_float_gap: assert property ($rose(chip_sel_n_q) |-> chip_sel_n_q [*3])
        else $error("no float gap");
    a_recall_no_write: assert property ($fell(mem_busy_q) |-> wr_en_n_q)
        else $error("write at recall end");
endmodule
bind nvh_host nvh_host_checker u_chk (.*);
`default_nettype wire

/* File: test/nvh_mem_model.sv */
`default_nettype none
module nvh_mem_model (
    // Device pins
    input wire logic [16:0] addr_in,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic [7:0] host_d,
    input wire logic host_oe,
    input wire logic power_good,
    output wire logic [7:0] data_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Array and pins
    // ****************
    logic [7:0] sram [int];
    logic [7:0] shadow [int];
    logic [7:0] rd_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic dirty = 1'b0;
    wire rd_on = !chip_sel_n && !out_en_n && wr_en_n && power_good;
    wire [17:0] sel_now = {rd_on, addr_in};
    wire [17:0] sel_dly;
    // Inertial delay: data only once address and strobes sat still a full access
    assign #35 sel_dly = sel_now;
    wire drive = rd_on && sel_dly === sel_now;
    always @(posedge drive) rd_q = sram.exists(addr_in) ? sram[addr_in] : 8'h00;
    always @(negedge drive) last_q = rd_q;
    always @(negedge host_oe) last_q = host_d;
    // Released bus shows the inverse so a stale sample cannot pass
    assign data_bus = host_oe ? host_d : drive ? rd_q : ~last_q;
    logic wr_armed = 1'b0;
    wire wr_on = !chip_sel_n && !wr_en_n;
    // Both strobes may rise in one step; the write lands once, when the pair leaves low
    always @(wr_on) begin
        if (wr_on === 1'b1) begin
            wr_armed = 1'b1;
        end else if (wr_armed) begin
            wr_armed = 1'b0;
            if (power_good) begin
                sram[addr_in] = host_oe ? host_d : 8'hxx;
                dirty = 1'b1;
            end
        end
    end
    always @(negedge power_good) begin
        if (dirty) shadow = sram;
        dirty = 1'b0;
    end
    always @(posedge power_good) sram = shadow;
endmodule
`default_nettype wire

/* File: test/tb_nvh_host.sv */
`default_nettype none
module tb_nvh_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, req_valid, req_write, power_good;
    logic req_ready_q, rsp_valid_q, mem_busy_q, chip_sel_n_q, out_en_n_q, wr_en_n_q;
    logic data_bus_oe_q;
    logic [16:0] req_addr, addr_in_q;
    logic [7:0] req_wdata, data_bus_i, rsp_rdata_q, data_bus_o_q;
    logic [7:0] ref_mem [int];
    logic [16:0] addrs [$];
    logic [31:0] rng;
    int n_mismatch = 0;
    int checked = 0;
    // ****************
    // Harness
    // ****************
    localparam int RESTORE_SIM = 20;
    localparam int STORE_SIM = 40;
    nvh_host #(.GRADE(0), .RESTORE_CYC(RESTORE_SIM), .STORE_CYC(STORE_SIM)) dut (.*);
    nvh_mem_model u_mem (.addr_in(addr_in_q), .chip_sel_n(chip_sel_n_q), .out_en_n(out_en_n_q),
        .wr_en_n(wr_en_n_q), .host_d(data_bus_o_q), .host_oe(data_bus_oe_q),
        .power_good(power_good), .data_bus(data_bus_i));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_byte(input logic [16:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait of one cycle; running out ends the run
    task automatic step(inout int n);
        @(negedge core_clk);
        n++;
        if (n > 500) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wait_ready(input logic rd, input logic [7:0] exp);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        while (req_ready_q !== 1'b1) begin
            step(n);
            if (rsp_valid_q === 1'b1) begin
                got = 1'b1;
                check(rsp_rdata_q, exp);
            end
        end
        if (rd) check({7'h00, got}, 8'h01);
    endtask
    task automatic do_req(input logic wr, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        while (chip_sel_n_q !== 1'b0) step(n);
        req_valid = 1'b0;
        if (wr) ref_mem[a] = d;
        wait_ready(!wr, exp_byte(a));
    endtask
    // Power returns mid-store: a dirty store must run out before the recall starts
    task automatic power_cycle(input logic was_dirty);
        int n;
        n = 0;
        power_good = 1'b0;
        repeat (8) @(negedge core_clk);
        check({7'h00, mem_busy_q}, 8'h01);
        power_good = 1'b1;
        while (req_ready_q !== 1'b1) step(n);
        check({7'h00, mem_busy_q}, 8'h00);
        check({7'h00, n > RESTORE_SIM + 10}, {7'h00, was_dirty});
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        {req_valid, req_write, req_addr, req_wdata} = '0;
        power_good = 1'b1;
        sys_rst = 1'b1;
        rng = 32'h0000_2496;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        // End addresses first, then random ones
        addrs = '{17'h0_0000, 17'h1_ffff};
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            addrs.push_back(rng[16:0]);
        end
        foreach (addrs[i]) begin
            rng = xs(rng);
            do_req(1'b1, addrs[i], rng[7:0]);
        end
        foreach (addrs[i]) do_req(1'b0, addrs[i], 8'h00);
        power_cycle(1'b1);
        foreach (addrs[i]) do_req(1'b0, addrs[i], 8'h00);
        power_cycle(1'b0);
        do_req(1'b0, addrs[1], 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
